// ===== asc_pkg.sv
// Constants, register map and types shared by the serial channel modules.
package asc_pkg;

   // Register indices on the plain register port.
   localparam int unsigned ASC_ADDR_W      = 3;
   localparam logic [2:0]  ASC_OFS_CONTROL = 3'h0;
   localparam logic [2:0]  ASC_OFS_MODE    = 3'h1;
   localparam logic [2:0]  ASC_OFS_DIVISOR = 3'h2;
   localparam logic [2:0]  ASC_OFS_ORDER   = 3'h3;
   localparam logic [2:0]  ASC_OFS_STATUS  = 3'h4;
   localparam logic [2:0]  ASC_OFS_TX_HOLD = 3'h5;
   localparam logic [2:0]  ASC_OFS_RX_HOLD = 3'h6;

   // serial_control fields.
   localparam int unsigned ASC_CTL_TIE   = 7;
   localparam int unsigned ASC_CTL_RIE   = 6;
   localparam int unsigned ASC_CTL_TE    = 5;
   localparam int unsigned ASC_CTL_RE    = 4;
   localparam int unsigned ASC_CTL_MULTIPROC_IRQ_EN  = 3;
   localparam int unsigned ASC_CTL_TX_DONE_IRQ_EN  = 2;

   // serial_mode fields.
   localparam int unsigned ASC_MOD_SYNC  = 7;
   localparam int unsigned ASC_MOD_CHR   = 6;
   localparam int unsigned ASC_MOD_PE    = 5;
   localparam int unsigned ASC_MOD_ODD   = 4;
   localparam int unsigned ASC_MOD_STOP  = 3;
   localparam int unsigned ASC_MOD_MP    = 2;
   localparam int unsigned ASC_MOD_CKS_L = 0;

   // bit_order_control field.
   localparam int unsigned ASC_ORD_MSB   = 3;

   // serial_status fields.
   localparam int unsigned ASC_STS_TDE   = 7;
   localparam int unsigned ASC_STS_RDF   = 6;
   localparam int unsigned ASC_STS_OVR   = 5;
   localparam int unsigned ASC_STS_FER   = 4;
   localparam int unsigned ASC_STS_PER   = 3;
   localparam int unsigned ASC_STS_TX_DONE_FLAG  = 2;
   localparam int unsigned ASC_STS_MPB   = 1;
   localparam int unsigned ASC_STS_MULTIPROC_TX_BIT  = 0;
   localparam logic [7:0]  ASC_STS_FLAGS = 8'hfc;

   // Reset values.
   localparam logic [7:0]  ASC_RST_ZERO    = 8'h00;
   localparam logic [7:0]  ASC_RST_DIVISOR = 8'hff;
   localparam logic [7:0]  ASC_RST_STATUS  = 8'h84;

   // Framing and timing.
   localparam int unsigned ASC_OVERSAMPLE = 16;
   localparam logic [3:0]  ASC_LEN7       = 4'h7;
   localparam logic [3:0]  ASC_LEN8       = 4'h8;
   localparam logic [5:0]  ASC_PRE_1      = 6'h00;
   localparam logic [5:0]  ASC_PRE_4      = 6'h03;
   localparam logic [5:0]  ASC_PRE_16     = 6'h0f;
   localparam logic [5:0]  ASC_PRE_64     = 6'h3f;

   typedef enum logic [1:0] {ASC_TX_IDLE, ASC_TX_SHIFT} asc_tx_state_t;
   typedef enum logic [1:0] {ASC_RX_IDLE, ASC_RX_START, ASC_RX_BITS} asc_rx_state_t;

   // Last count of the peripheral clock prescaler for each baud clock select.
   function automatic logic [5:0] asc_presc_last(input logic [1:0] sel);
      return (sel == 2'h0) ? ASC_PRE_1 : (sel == 2'h1) ? ASC_PRE_4 : (sel == 2'h2) ? ASC_PRE_16 : ASC_PRE_64;
   endfunction : asc_presc_last

endpackage : asc_pkg

// ===== asc_baud_if.sv
// Link between the channel core and its baud rate generator.
`timescale 1ns/1ps
interface asc_baud_if;
   logic       tick;
   logic [7:0] divisor;
   logic [1:0] clk_sel;
   logic       run;

   modport gen  (output tick, input divisor, input clk_sel, input run);
   modport user (input tick, output divisor, output clk_sel, output run);
endinterface : asc_baud_if

// ===== asc_baud_gen.sv
// Baud rate generator: prescaler and 8-bit divisor giving the oversampling tick.
`timescale 1ns/1ps
module asc_baud_gen
   import asc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   asc_baud_if.gen  bif
);

   logic [5:0] pre_cnt_reg;
   logic [7:0] div_cnt_reg;
   logic       tick_reg;

   wire logic [5:0] pre_last = asc_presc_last(bif.clk_sel);
   wire logic       pre_hit  = (pre_cnt_reg == pre_last);
   wire logic       div_hit  = (div_cnt_reg == bif.divisor);

   // The tick rate is clock / (prescale * (divisor + 1)), so a divisor of 0 is legal.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_reg <= 6'h00;
         div_cnt_reg <= 8'h00;
         tick_reg    <= 1'b0;
      end else if (!bif.run) begin
         pre_cnt_reg <= 6'h00;
         div_cnt_reg <= 8'h00;
         tick_reg    <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_hit ? 6'h00 : pre_cnt_reg + 6'h01;
         if (pre_hit) begin
            div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01;
         end
         tick_reg <= pre_hit & div_hit;
      end
   end

   assign bif.tick = tick_reg;

endmodule : asc_baud_gen

// ===== asc_channel.sv
// One asynchronous serial channel: registers, transmitter and receiver.
`timescale 1ns/1ps

// Overview of operation
// (R1) Completed frame moves into receive holding register.
// (R2) Received character sets the receive-full flag.
// (R3) Software reads data, clears receive-full before next.
// (R4) Software writes transmit data, clears transmit-empty.
// (R5) Load into shifter sets transmit-empty, sends character.
// (R6) Status flags clear on written 0 only; the transmit-end flag also clears when a character loads into the shifter.
// (R7) Only hardware sets the status flags.
// (R8) Transmit interrupt enable gates transmit-empty request.
// (R9) Receive interrupt enable gates receive and error requests.
// (R10) Transmit-end interrupt enable gates transmit-end request.
// (R11) Transmitter runs only while transmit enable set.
// (R12) Receiver runs only while receive enable set.
// (R13) Multiprocessor interrupt enable needs async multiprocessor mode.
// (R14) Communication-mode bit zero selects asynchronous framing.
// (R15) Character-length bit zero gives eight data bits.
// (R16) Parity-enable zero omits parity bit and check.
// (R17) Parity sense picks odd or even when enabled.
// (R18) Stop-length zero means one stop bit.
// (R19) Multiprocessor-mode zero means no multiprocessor bit.
// (R20) Clock select 00 uses undivided peripheral clock.
// (R21) Eight-bit divisor sets the serial bit period.
// (R22) Bit 3 of bit order control selects MSB-first.
// (R23) Frame while receive-full set: overrun, character dropped.
// (R24) Low stop bit flags framing, mismatch flags parity.
// (R25) Transmit start, data, parity, then stop bits.
module asc_channel
   import asc_pkg::*;
#(
   parameter int unsigned OVERSAMPLE = ASC_OVERSAMPLE
)(
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [ASC_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  serial_in_pin,
   output logic                       serial_out_pin,
   output logic                       tx_empty_irq,
   output logic                       rx_full_irq,
   output logic                       rx_error_irq,
   output logic                       tx_done_irq
);

   localparam int unsigned OS_W = $clog2(OVERSAMPLE);
   localparam logic [OS_W-1:0] OS_LAST = OS_W'(OVERSAMPLE - 1);
   localparam logic [OS_W-1:0] OS_MID  = OS_W'(OVERSAMPLE / 2 - 1);

   if (OVERSAMPLE < 4 || (OVERSAMPLE & (OVERSAMPLE - 1)) != 0) begin : g_bad_oversample
      $error("OVERSAMPLE must be a power of two of at least 4.");
   end

   // Places the data bits in line order: reversed when MSB-first, 7-bit data in the low bits.
   function automatic logic [7:0] order_bits(input logic [7:0] d, input logic seven, input logic msb);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (seven) begin
            if (i < 7) r[i] = msb ? d[6-i] : d[i];
         end else begin
            r[i] = msb ? d[7-i] : d[i];
         end
      end
      return r;
   endfunction : order_bits

   // Parity bit for the character; even sense makes the count of ones even.
   function automatic logic data_parity(input logic [7:0] d, input logic seven, input logic odd);
      return (^(seven ? {1'b0, d[6:0]} : d)) ^ odd;
   endfunction : data_parity

   // ---------------------------------------------------------------- registers
   logic [7:0]    control_reg;
   logic [7:0]    mode_reg;
   logic [7:0]    divisor_reg;
   logic [7:0]    order_reg;
   logic [7:0]    status_reg;
   logic [7:0]    tx_holding_reg;
   logic [7:0]    rx_holding_reg;
   logic [7:0]    rdata_reg;
   logic          serial_out_reg;
   logic          tx_empty_irq_reg;
   logic          rx_full_irq_reg;
   logic          rx_error_irq_reg;
   logic          tx_done_irq_reg;

   asc_tx_state_t tx_state_reg;
   logic [11:0]   tx_shifter_reg;
   logic [3:0]    tx_left_reg;
   logic [OS_W-1:0] tx_os_reg;

   asc_rx_state_t rx_state_reg;
   logic [10:0]   rx_shifter_reg;
   logic [3:0]    rx_idx_reg;
   logic [OS_W-1:0] rx_os_reg;

   asc_baud_if bif ();

   // ---------------------------------------------------------------- decoding
   wire logic wr_control = reg_wr && (reg_addr == ASC_OFS_CONTROL);
   wire logic wr_mode    = reg_wr && (reg_addr == ASC_OFS_MODE);
   wire logic wr_divisor = reg_wr && (reg_addr == ASC_OFS_DIVISOR);
   wire logic wr_order   = reg_wr && (reg_addr == ASC_OFS_ORDER);
   wire logic wr_status  = reg_wr && (reg_addr == ASC_OFS_STATUS);
   wire logic wr_tx_hold = reg_wr && (reg_addr == ASC_OFS_TX_HOLD);

   wire logic tx_enable      = control_reg[ASC_CTL_TE];
   wire logic rx_enable      = control_reg[ASC_CTL_RE];
   wire logic sync_mode      = mode_reg[ASC_MOD_SYNC];
   wire logic seven          = mode_reg[ASC_MOD_CHR];           // see (R15)
   wire logic parity_enable  = mode_reg[ASC_MOD_PE];            // see (R16)
   wire logic parity_odd     = mode_reg[ASC_MOD_ODD];           // see (R17)
   wire logic two_stop       = mode_reg[ASC_MOD_STOP];          // see (R18)
   wire logic msb_first      = order_reg[ASC_ORD_MSB];          // see (R22)

   // Parity takes the extra slot when both parity and multiprocessor mode are chosen.
   wire logic mp_active      = mode_reg[ASC_MOD_MP] & ~parity_enable & ~sync_mode;   // see (R19) (R14)
   wire logic extra_slot     = parity_enable | mp_active;
   wire logic mp_filter      = control_reg[ASC_CTL_MULTIPROC_IRQ_EN] & mp_active;                // see (R13)

   wire logic [3:0] n_data   = seven ? ASC_LEN7 : ASC_LEN8;
   wire logic [3:0] rx_last  = n_data + 4'(extra_slot);
   wire logic [3:0] tx_len   = n_data + 4'(extra_slot) + 4'h2 + 4'(two_stop);

   // Baud generator: clock select 00 means the peripheral clock feeds it undivided.
   assign bif.divisor = divisor_reg;                               // see (R21)
   assign bif.clk_sel = mode_reg[ASC_MOD_CKS_L +: 2];              // see (R20)
   assign bif.run     = tx_enable | rx_enable;

   asc_baud_gen u_baud (
      .clock (clock),
      .rst_n (rst_n),
      .bif   (bif)
   );

   // ---------------------------------------------------------------- transmit path
   wire logic [7:0] tx_ordered = order_bits(tx_holding_reg, seven, msb_first);
   wire logic       tx_parity  = data_parity(tx_holding_reg, seven, parity_odd);
   wire logic       tx_extra   = parity_enable ? tx_parity : status_reg[ASC_STS_MULTIPROC_TX_BIT];

   // Line image sent LSB of the vector first: start, data, extra slot, stop bits.
   logic [11:0] tx_frame;
   always_comb begin
      tx_frame    = 12'hfff;
      tx_frame[0] = 1'b0;                                          // see (R25)
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n_data) tx_frame[i+1] = tx_ordered[i];
      end
      if (extra_slot) tx_frame[n_data + 4'h1] = tx_extra;          // see (R16) (R17)
   end

   // A character leaves holding only once software has cleared transmit-empty.
   wire logic tx_load   = tx_enable && (tx_state_reg == ASC_TX_IDLE) && !status_reg[ASC_STS_TDE];  // see (R4) (R11)
   wire logic tx_bitend = (tx_state_reg == ASC_TX_SHIFT) && bif.tick && (tx_os_reg == OS_LAST);
   wire logic tx_finish = tx_bitend && (tx_left_reg == 4'h1);
   wire logic tx_done   = tx_finish && status_reg[ASC_STS_TDE];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg   <= ASC_TX_IDLE;
         tx_shifter_reg <= 12'hfff;
         tx_left_reg    <= 4'h0;
         tx_os_reg      <= '0;
      end else if (!tx_enable) begin                               // see (R11)
         tx_state_reg   <= ASC_TX_IDLE;
         tx_shifter_reg <= 12'hfff;
      end else if (tx_load) begin                                  // see (R5)
         tx_state_reg   <= ASC_TX_SHIFT;
         tx_shifter_reg <= tx_frame;
         tx_left_reg    <= tx_len;
         tx_os_reg      <= '0;
      end else if (tx_state_reg == ASC_TX_SHIFT && bif.tick) begin
         tx_os_reg <= tx_os_reg + 1'b1;
         if (tx_bitend) begin
            tx_shifter_reg <= {1'b1, tx_shifter_reg[11:1]};        // see (R25)
            tx_left_reg    <= tx_left_reg - 4'h1;
            if (tx_finish) tx_state_reg <= ASC_TX_IDLE;
         end
      end
   end

   // ---------------------------------------------------------------- receive path
   wire logic rx_os_end  = bif.tick && (rx_os_reg == OS_LAST);
   wire logic rx_mid     = bif.tick && (rx_os_reg == OS_MID);
   wire logic rx_done    = (rx_state_reg == ASC_RX_BITS) && rx_os_end && (rx_idx_reg == rx_last);

   // The shifter is cleared at the start bit, so OR-ing in the newest sample is exact.
   wire logic [10:0] rx_bits     = rx_shifter_reg | (11'(serial_in_pin) << rx_idx_reg);
   wire logic [7:0]  rx_raw      = seven ? {1'b0, rx_bits[6:0]} : rx_bits[7:0];
   wire logic [7:0]  rx_data     = order_bits(rx_raw, seven, msb_first);        // see (R22)
   wire logic        rx_extra    = rx_bits[n_data];
   wire logic        rx_stop     = rx_bits[rx_last];
   wire logic        parity_bad  = parity_enable && (rx_extra != data_parity(rx_raw, seven, parity_odd)); // see (R17)

   // While waiting for an address frame, data frames are dropped without any flag.
   wire logic mp_drop    = mp_filter && !rx_extra;                 // see (R13)
   wire logic rx_accept  = rx_done && !mp_drop;
   wire logic rx_overrun = rx_accept && status_reg[ASC_STS_RDF];   // see (R23)
   wire logic rx_store   = rx_accept && !status_reg[ASC_STS_RDF];  // see (R1)
   wire logic mp_wake    = rx_store && mp_filter;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg   <= ASC_RX_IDLE;
         rx_shifter_reg <= 11'h000;
         rx_idx_reg     <= 4'h0;
         rx_os_reg      <= '0;
      end else if (!rx_enable) begin                               // see (R12)
         rx_state_reg <= ASC_RX_IDLE;
      end else begin
         unique case (rx_state_reg)
            ASC_RX_IDLE: begin
               if (!serial_in_pin) begin
                  rx_state_reg <= ASC_RX_START;
                  rx_os_reg    <= '0;
               end
            end
            ASC_RX_START: begin
               if (rx_mid) begin
                  // A start bit that is high again at mid-bit was a glitch.
                  rx_state_reg   <= serial_in_pin ? ASC_RX_IDLE : ASC_RX_BITS;
                  rx_os_reg      <= '0;
                  rx_idx_reg     <= 4'h0;
                  rx_shifter_reg <= 11'h000;
               end else if (bif.tick) begin
                  rx_os_reg <= rx_os_reg + 1'b1;
               end
            end
            ASC_RX_BITS: begin
               if (bif.tick) begin
                  rx_os_reg <= rx_os_reg + 1'b1;
               end
               if (rx_os_end) begin
                  rx_shifter_reg <= rx_bits;
                  rx_idx_reg     <= rx_idx_reg + 4'h1;
                  // Only the first stop bit is checked, so two-stop frames rearm early.
                  if (rx_done) rx_state_reg <= ASC_RX_IDLE;        // see (R18)
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------- status
   // Hardware sets win over a software clear in the same cycle.
   wire logic [7:0] st_set =
      (8'(tx_load)                  << ASC_STS_TDE)   |            // see (R5)
      (8'(rx_store)                 << ASC_STS_RDF)   |            // see (R2)
      (8'(rx_overrun)               << ASC_STS_OVR)   |            // see (R23)
      (8'(rx_store && !rx_stop)     << ASC_STS_FER)   |            // see (R24)
      (8'(rx_store && parity_bad)   << ASC_STS_PER)   |            // see (R24)
      (8'(tx_done)                  << ASC_STS_TX_DONE_FLAG);              // see (R7)
   wire logic [7:0] st_clear  = wr_status ? (~reg_wdata & ASC_STS_FLAGS) : ASC_RST_ZERO;   // see (R6)
   wire logic [7:0] st_keep   = tx_load ? ~(8'h01 << ASC_STS_TX_DONE_FLAG) : 8'hff;
   wire logic [7:0] st_flags  = (((status_reg & ~st_clear) & st_keep) | st_set) & ASC_STS_FLAGS; // see (R7)
   wire logic       mpb_next  = (rx_store && mp_active) ? rx_extra : status_reg[ASC_STS_MPB];
   wire logic       multiproc_tx_bit_next = wr_status ? reg_wdata[ASC_STS_MULTIPROC_TX_BIT] : status_reg[ASC_STS_MULTIPROC_TX_BIT];
   wire logic [7:0] status_next = st_flags | (8'(mpb_next) << ASC_STS_MPB) | (8'(multiproc_tx_bit_next) << ASC_STS_MULTIPROC_TX_BIT);

   // An accepted address frame ends the wait, overriding a same-cycle write.
   wire logic [7:0] control_wr   = wr_control ? reg_wdata : control_reg;
   wire logic [7:0] control_next = mp_wake ? (control_wr & ~(8'h01 << ASC_CTL_MULTIPROC_IRQ_EN)) : control_wr; // see (R13)

   // ---------------------------------------------------------------- read data
   wire logic [7:0] rd_mux =
      (reg_addr == ASC_OFS_CONTROL) ? control_reg    :
      (reg_addr == ASC_OFS_MODE)    ? mode_reg       :
      (reg_addr == ASC_OFS_DIVISOR) ? divisor_reg    :
      (reg_addr == ASC_OFS_ORDER)   ? order_reg      :
      (reg_addr == ASC_OFS_STATUS)  ? status_reg     :
      (reg_addr == ASC_OFS_TX_HOLD) ? tx_holding_reg :
      (reg_addr == ASC_OFS_RX_HOLD) ? rx_holding_reg : ASC_RST_ZERO;   // see (R3)

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control_reg    <= ASC_RST_ZERO;
         mode_reg       <= ASC_RST_ZERO;
         divisor_reg    <= ASC_RST_DIVISOR;
         order_reg      <= ASC_RST_ZERO;
         status_reg     <= ASC_RST_STATUS;
         tx_holding_reg <= ASC_RST_ZERO;
         rx_holding_reg <= ASC_RST_ZERO;
         rdata_reg      <= ASC_RST_ZERO;
      end else begin
         control_reg <= control_next;
         status_reg  <= status_next;
         if (wr_mode)    mode_reg       <= reg_wdata;
         if (wr_divisor) divisor_reg    <= reg_wdata;
         if (wr_order)   order_reg      <= reg_wdata;
         if (wr_tx_hold) tx_holding_reg <= reg_wdata;              // see (R4)
         if (rx_store)   rx_holding_reg <= rx_data;                // see (R1) (R23)
         rdata_reg <= reg_rd ? rd_mux : ASC_RST_ZERO;
      end
   end

   // ---------------------------------------------------------------- pins and requests
   // Registered one cycle behind the shifter so the pin comes straight from a flip-flop.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_reg   <= 1'b1;
         tx_empty_irq_reg <= 1'b0;
         rx_full_irq_reg  <= 1'b0;
         rx_error_irq_reg <= 1'b0;
         tx_done_irq_reg  <= 1'b0;
      end else begin
         serial_out_reg   <= (tx_state_reg == ASC_TX_SHIFT) ? tx_shifter_reg[0] : 1'b1;          // see (R5)
         tx_empty_irq_reg <= control_reg[ASC_CTL_TIE]  & status_reg[ASC_STS_TDE];                // see (R8)
         rx_full_irq_reg  <= control_reg[ASC_CTL_RIE]  & status_reg[ASC_STS_RDF];                // see (R9)
         rx_error_irq_reg <= control_reg[ASC_CTL_RIE]  &
                             (status_reg[ASC_STS_OVR] | status_reg[ASC_STS_FER] | status_reg[ASC_STS_PER]); // see (R9)
         tx_done_irq_reg  <= control_reg[ASC_CTL_TX_DONE_IRQ_EN] & status_reg[ASC_STS_TX_DONE_FLAG];               // see (R10)
      end
   end

   assign reg_rdata      = rdata_reg;
   assign serial_out_pin = serial_out_reg;
   assign tx_empty_irq   = tx_empty_irq_reg;
   assign rx_full_irq    = rx_full_irq_reg;
   assign rx_error_irq   = rx_error_irq_reg;
   assign tx_done_irq    = tx_done_irq_reg;

endmodule : asc_channel

// ===== asc_channel_assertions.sv
// Port-level assertions and covers for one serial channel.
`timescale 1ns/1ps
module asc_channel_assertions
   import asc_pkg::*;
#(
   parameter int unsigned OVERSAMPLE = ASC_OVERSAMPLE
)(
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire logic [ASC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  serial_in_pin,
   input wire logic                  serial_out_pin,
   input wire logic                  tx_empty_irq,
   input wire logic                  rx_full_irq,
   input wire logic                  rx_error_irq,
   input wire logic                  tx_done_irq
);
   logic [7:0] ctl_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // The channel's registers are hidden, so serial_control is shadowed from the write port.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ctl_reg <= 8'h00;
      else if (reg_wr && reg_addr == ASC_OFS_CONTROL) ctl_reg <= reg_wdata;
   end
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
      else $error("unmapped index read not zero");
   divisor_readback_a: assert property (reg_wr && reg_addr == ASC_OFS_DIVISOR ##1 reg_rd && reg_addr == ASC_OFS_DIVISOR
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("divisor readback wrong");
   tx_irq_mask_a: assert property (!$past(ctl_reg[ASC_CTL_TIE]) |-> !tx_empty_irq)
      else $error("transmit irq while masked");
   rx_irq_mask_a: assert property (!$past(ctl_reg[ASC_CTL_RIE]) |-> !rx_full_irq && !rx_error_irq)
      else $error("receive irq while masked");
   done_irq_mask_a: assert property (!$past(ctl_reg[ASC_CTL_TX_DONE_IRQ_EN]) |-> !tx_done_irq)
      else $error("transmit end irq while masked");
   tx_idle_a: assert property (!ctl_reg[ASC_CTL_TE] && !$past(ctl_reg[ASC_CTL_TE]) && !$past(ctl_reg[ASC_CTL_TE], 2)
      |-> serial_out_pin) else $error("transmit line active while disabled");
   start_len_a: assert property ($fell(serial_out_pin) && ctl_reg[ASC_CTL_TE] |=> !serial_out_pin [*2])
      else $error("start bit too short");
   cover property ($rose(rx_full_irq));
   cover property ($rose(tx_done_irq));
   cover property ($fell(serial_out_pin));
endmodule : asc_channel_assertions

bind asc_channel asc_channel_assertions #(.OVERSAMPLE(OVERSAMPLE)) u_chk (.clock(clock), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .tx_empty_irq(tx_empty_irq),
   .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));

// ===== asc_peer.sv
// Remote serial peer: drives the receive line and captures the transmit line.
`timescale 1ns/1ps
module asc_peer #(
   parameter int BIT_CYC = 4
)(
   input wire logic clock,
   input wire logic line_in,
   output logic     line_out
);
   initial line_out = 1'b1;
   // Sends n line bits, bit 0 first; the caller builds the whole frame.
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (BIT_CYC) @(posedge clock);
      end
      line_out <= 1'b1;
   endtask : send
   // Sampling on the falling edge keeps clear of the channel's registered pin update.
   task automatic grab(input int n, output logic [11:0] bits);
      int w;
      bits = 12'h000;
      w = 0;
      while (line_in && w < 400) begin
         @(negedge clock);
         w++;
      end
      if (w == 400) bits = 'x;
      repeat (BIT_CYC / 2) @(negedge clock);
      for (int i = 0; i < n; i++) begin
         bits[i] = line_in;
         repeat (BIT_CYC) @(negedge clock);
      end
   endtask : grab
endmodule : asc_peer

// ===== tb_top.sv
// Self-checking bench for the serial channel.
`timescale 1ns/1ps
module tb_top;
   import asc_pkg::*;
   localparam int OS = 4;
   logic       clock, rst_n, reg_wr, reg_rd, rx_line, tx_line;
   logic       tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [11:0] bits;
   int         fails = 0;
   int         samples_checked = 0;
   always #12.5 clock = ~clock;
   asc_channel #(.OVERSAMPLE(OS)) i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(rx_line), .serial_out_pin(tx_line),
      .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));
   asc_peer #(.BIT_CYC(OS)) i_peer (.clock(clock), .line_in(tx_line), .line_out(rx_line));
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // A strobe still pending from the previous write gets one edge low before the next.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      if (reg_wr) @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk({4'h0, reg_rdata}, {4'h0, e});
      @(posedge clock);
   endtask : rd
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      results();
   end
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(ASC_OFS_STATUS, ASC_RST_STATUS);
      wr(ASC_OFS_STATUS, 8'hfc);
      rd(ASC_OFS_STATUS, ASC_RST_STATUS);
      rd(3'h7, 8'h00);
      wr(ASC_OFS_DIVISOR, 8'h00);
      rd(ASC_OFS_DIVISOR, 8'h00);
      wr(ASC_OFS_CONTROL, 8'h30);
      i_peer.send({1'b1, 8'ha5, 1'b0}, 10);
      rd(ASC_OFS_RX_HOLD, 8'ha5);
      rd(ASC_OFS_STATUS, 8'hc4);
      i_peer.send({1'b1, 8'h3c, 1'b0}, 10);
      rd(ASC_OFS_STATUS, 8'he4);
      rd(ASC_OFS_RX_HOLD, 8'ha5);
      wr(ASC_OFS_STATUS, 8'h9c);
      i_peer.send({1'b0, 8'h5a, 1'b0}, 10);
      rd(ASC_OFS_STATUS, 8'hd4);
      rd(ASC_OFS_RX_HOLD, 8'h5a);
      wr(ASC_OFS_STATUS, 8'h8c);
      wr(ASC_OFS_TX_HOLD, 8'h96);
      wr(ASC_OFS_STATUS, 8'h7c);
      i_peer.grab(10, bits);
      @(posedge clock);
      chk(bits, {2'b00, 1'b1, 8'h96, 1'b0});
      rd(ASC_OFS_STATUS, ASC_RST_STATUS);
      wr(ASC_OFS_ORDER, 8'h08);
      wr(ASC_OFS_MODE, 8'h20);
      wr(ASC_OFS_TX_HOLD, 8'h97);
      wr(ASC_OFS_STATUS, 8'h7c);
      i_peer.grab(11, bits);
      @(posedge clock);
      chk(bits, {1'b0, 1'b1, ^8'h97, {<<{8'h97}}, 1'b0});
      wr(ASC_OFS_MODE, 8'h30);
      // Parity bit below gives an even count, wrong for odd sense.
      i_peer.send({1'b1, ^8'h97, {<<{8'h97}}, 1'b0}, 11);
      rd(ASC_OFS_RX_HOLD, 8'h97);
      rd(ASC_OFS_STATUS, 8'hcc);
      wr(ASC_OFS_CONTROL, 8'hf4);
      repeat (3) @(posedge clock);
      chk({8'h00, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq}, 12'h00f);
      wr(ASC_OFS_CONTROL, 8'h30);
      repeat (3) @(posedge clock);
      chk({8'h00, tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq}, 12'h000);
      wr(ASC_OFS_STATUS, 8'h84);
      wr(ASC_OFS_CONTROL, 8'h00);
      i_peer.send({1'b1, 8'h11, 1'b0}, 10);
      rd(ASC_OFS_STATUS, ASC_RST_STATUS);
      // Seven data bits, LSB first, two stop bits.
      wr(ASC_OFS_ORDER, 8'h00);
      wr(ASC_OFS_MODE, 8'h48);
      wr(ASC_OFS_CONTROL, 8'h30);
      wr(ASC_OFS_TX_HOLD, 8'h5a);
      wr(ASC_OFS_STATUS, 8'h7c);
      i_peer.grab(10, bits);
      @(posedge clock);
      chk(bits, {2'b00, 2'b11, 7'h5a, 1'b0});
      results();
   end
endmodule : tb_top
